/* include/ipc_defines.svh */
// Constants for the plug and play configuration register block.
// Assumes inclusion by bare name from design and verification files.
`ifndef IPC_DEFINES_SVH
`define IPC_DEFINES_SVH

// ---------------------------------------------------------------
// Fixed auto-configuration port addresses
// ---------------------------------------------------------------
`define IPC_INDEX_PORT 12'h279
`define IPC_WDATA_PORT 12'hA79
`define IPC_RPORT_LOW 2'h3
`define IPC_RPORT_HIGH 2'h0

// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define IPC_IDX_RPORT 8'h00
`define IPC_IDX_ISOL 8'h01
`define IPC_IDX_CMD 8'h02
`define IPC_IDX_WAKE 8'h03
`define IPC_IDX_RDATA 8'h04
`define IPC_IDX_STAT 8'h05
`define IPC_IDX_CARDNUM 8'h06
`define IPC_IDX_LUN 8'h07
`define IPC_IDX_ACT 8'h30
`define IPC_IDX_RCHK 8'h31
`define IPC_IDX_ROMH 8'h40
`define IPC_IDX_ROML 8'h41
`define IPC_IDX_MCTL 8'h42
`define IPC_IDX_BACKUP 8'hF5

// ---------------------------------------------------------------
// Command bits, field masks and fixed values
// ---------------------------------------------------------------
`define IPC_CMD_RESET 0
`define IPC_CMD_WAITKEY 1
`define IPC_CMD_CLRNUM 2
`define IPC_ACT_BIT 0
`define IPC_RCHK_EN 1
`define IPC_RCHK_PAT 0
`define IPC_ROMH_MASK 8'h0D
`define IPC_ROML_MASK 8'hC0
`define IPC_PAT_SET 8'h55
`define IPC_PAT_CLR 8'hAA
`define IPC_ZERO 8'h00
`define IPC_LUN_VALUE 8'h00
`define IPC_MCTL_VALUE 8'h00

// ---------------------------------------------------------------
// Power-up values and initiation key generator
// ---------------------------------------------------------------
`define IPC_RST_RPORT 8'h00
`define IPC_RST_CARDNUM 8'h00
`define IPC_RST_ACT 8'h00
`define IPC_RST_RCHK 8'h00
`define IPC_RST_ROMH 8'h00
`define IPC_RST_ROML 8'h00
`define IPC_KEY_SEED 8'h6A
`define IPC_KEY_LEN 6'd32
`define IPC_KEY_LAST 6'd31

`endif

/* include/ipc_pkg.sv */
// Types shared by the plug and play configuration block.
// Assumes nothing of its surroundings.
package ipc_pkg;

  // ---------------------------------------------------------------
  // Card states, Gray coded along wait, sleep, isolate, config
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IPC_WAITKEY = 2'h0,
    IPC_SLEEP = 2'h1,
    IPC_ISOLATE = 2'h3,
    IPC_CONFIG = 2'h2
  } ipc_state_t;

endpackage

/* rtl/ipc_config_regs.sv */
// Plug and play card and logical device configuration registers.
// Assumes ISA strobes, address and data arrive as raw pins; range hit,
// resource and isolation inputs come from logic on sys_clk.
// Summary of operation
// R01: Decode write index port 279H, write data A79H, movable read port.
// R02: Index is kept for any number of data accesses until rewritten.
// R03: Index port writes are watched for the initiation key sequence.
// R04: Undefined registers and bits are read-only and return zero.
// R05: Index 00H write sets read port address bits 9..2; bits 1..0 ones.
// R06: Reading 01H in isolation triggers one serial identifier bit compare.
// R07: Command bit 0 resets the logical device registers, keeping the number.
// R08: Command bit 1 returns the card to key wait, keeping the number.
// R09: Command bit 2 clears card number and its backup copy.
// R10: Command bits clear themselves in hardware after acting.
// R11: Wake write moves matching sleeping card to isolation or config.
// R12: Index 04H gives next resource byte; 05H bit 0 flags readiness.
// R13: Card number write also records the backup copy.
// R14: Index 07H reads zero, one logical unit only.
// R15: Activate bit 0 is read/write and enables the logical unit.
// R16: Host disables range check before activating the unit.
// R17: Range check bit 1 acts only while the unit is inactive.
// R18: Range check reads return 55H with bit 0 set, else AAH.
// R19: Boot ROM high: bits 23..20 and 17 read zero, rest writable.
// R20: Boot ROM low: bits 13..8 read zero, rest writable.
// R21: Memory control at 42H reads zero, eight bit ROM access only.
// R22: Boot ROM size comes from serial memory, not these registers.
// R23: Read port returns indexed register; write port updates it.
// R24: Data accesses act only in states that permit them.
`timescale 1ns/1ps

`include "ipc_defines.svh"

module ipc_config_regs
  import ipc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [11:0] isaAddr,
  input wire logic [7:0] isaDataIn,
  input wire logic isaIorN,
  input wire logic isaIowN,
  output logic [7:0] isaDataOut,
  output logic isaDataOe,
  input wire logic ioRangeHit,
  input wire logic [7:0] resourceByte,
  input wire logic resourceReady,
  output logic resourceNext,
  input wire logic [7:0] isolationData,
  output logic isolationCompare,
  input wire logic [1:0] romSizeCfg,
  output logic [1:0] bootRomSize,
  output logic [15:0] bootRomBase,
  output logic unitActive,
  output logic rangeCheckActive,
  output logic [7:0] cardNumberBackup,
  output logic [1:0] cardState
);

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  logic [1:0] strobeSync;
  logic [19:0] busSync;
  logic iorPrev_q;
  logic iowPrev_q;

  ipc_sync #(.WIDTH(2), .INIT(2'h3)) uStrobeSync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pinIn({isaIorN, isaIowN}),
    .syncOut(strobeSync)
  );

  ipc_sync #(.WIDTH(20), .INIT(20'h00000)) uBusSync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pinIn({isaAddr, isaDataIn}),
    .syncOut(busSync)
  );

  logic iorN;
  logic iowN;
  logic [11:0] addr;
  logic [7:0] wdata;
  assign iorN = strobeSync[1];
  assign iowN = strobeSync[0];
  assign addr = busSync[19:8];
  assign wdata = busSync[7:0];

  // Previous strobe levels give single-cycle start-of-access pulses.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      iorPrev_q <= 1'b1;
      iowPrev_q <= 1'b1;
    end else begin
      iorPrev_q <= iorN;
      iowPrev_q <= iowN;
    end
  end

  // ---------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------
  ipc_state_t state_q;
  logic [7:0] rport_q;
  logic [7:0] index_q;
  logic readStart;
  logic writeStart;
  logic idxWrite;
  logic dataWrite;
  logic rportHit;
  logic dataRead;

  assign readStart = iorPrev_q && !iorN;
  assign writeStart = iowPrev_q && !iowN;
  // R01 port decode
  assign idxWrite = writeStart && (addr == `IPC_INDEX_PORT);
  assign dataWrite = writeStart && (addr == `IPC_WDATA_PORT);
  // R05 read port shape
  assign rportHit = (addr == {`IPC_RPORT_HIGH, rport_q, `IPC_RPORT_LOW});
  logic rportHit_ok;
  // R24 reads only once isolated or configured
  assign rportHit_ok = rportHit && (state_q == IPC_ISOLATE || state_q == IPC_CONFIG);
  assign dataRead = readStart && rportHit_ok;

  // ---------------------------------------------------------------
  // Initiation key detector
  // ---------------------------------------------------------------
  logic [7:0] keyLfsr_q;
  logic [5:0] keyCount_q;
  logic keyDone;

  // R03 key sequence watch
  assign keyDone = idxWrite && (wdata == keyLfsr_q) && (keyCount_q == `IPC_KEY_LAST);

  // A mismatch restarts the sequence; the check only runs in key wait.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      keyLfsr_q <= `IPC_KEY_SEED;
      keyCount_q <= 6'd0;
    end else if (idxWrite) begin
      if (state_q == IPC_WAITKEY && wdata == keyLfsr_q && keyCount_q != `IPC_KEY_LAST) begin
        keyLfsr_q <= {keyLfsr_q[1] ^ keyLfsr_q[0], keyLfsr_q[7:1]};
        keyCount_q <= keyCount_q + 6'd1;
      end else begin
        keyLfsr_q <= `IPC_KEY_SEED;
        keyCount_q <= 6'd0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Index register
  // ---------------------------------------------------------------
  // R02 index held until rewritten
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      index_q <= `IPC_ZERO;
    end else if (idxWrite && state_q != IPC_WAITKEY) begin
      index_q <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // Write qualification
  // ---------------------------------------------------------------
  logic inConfig;
  logic inIsolate;
  logic wrRport;
  logic wrCmd;
  logic wrWake;
  logic wrCardNum;
  logic wrCfg;
  logic [2:0] cmd_q;

  assign inConfig = (state_q == IPC_CONFIG);
  assign inIsolate = (state_q == IPC_ISOLATE);
  // R24 writes gated by card state
  assign wrRport = dataWrite && (inConfig || inIsolate) && (index_q == `IPC_IDX_RPORT);
  assign wrCmd = dataWrite && (state_q != IPC_WAITKEY) && (index_q == `IPC_IDX_CMD);
  assign wrWake = dataWrite && (state_q != IPC_WAITKEY) && (index_q == `IPC_IDX_WAKE);
  assign wrCardNum = dataWrite && (inConfig || inIsolate) && (index_q == `IPC_IDX_CARDNUM);
  assign wrCfg = dataWrite && inConfig;

  // R10 command bits self-clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= 3'h0;
    end else if (wrCmd) begin
      cmd_q <= wdata[2:0];
    end else begin
      cmd_q <= 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // Card state machine
  // ---------------------------------------------------------------
  logic [7:0] cardNum_q;

  // Wait-for-key command takes priority over any wake in the same cycle.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= IPC_WAITKEY;
    end else if (cmd_q[`IPC_CMD_WAITKEY]) begin
      // R08 return to key wait
      state_q <= IPC_WAITKEY;
    end else begin
      case (state_q)
        IPC_WAITKEY: begin
          if (keyDone) begin
            state_q <= IPC_SLEEP;
          end
        end
        IPC_SLEEP: begin
          // R11 wake on matching number
          if (wrWake && wdata == cardNum_q) begin
            state_q <= (wdata == `IPC_ZERO) ? IPC_ISOLATE : IPC_CONFIG;
          end
        end
        IPC_ISOLATE: begin
          if (wrCardNum) begin
            state_q <= IPC_CONFIG;
          end else if (wrWake && wdata != cardNum_q) begin
            state_q <= IPC_SLEEP;
          end
        end
        IPC_CONFIG: begin
          if (wrWake && wdata != cardNum_q) begin
            state_q <= IPC_SLEEP;
          end
        end
        default: begin
          state_q <= IPC_WAITKEY;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Card registers
  // ---------------------------------------------------------------
  // R05 read port locator
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rport_q <= `IPC_RST_RPORT;
    end else if (wrRport) begin
      rport_q <= wdata;
    end
  end

  // The backup copy survives the device reset command, like the number.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cardNum_q <= `IPC_RST_CARDNUM;
      cardNumberBackup <= `IPC_RST_CARDNUM;
    end else if (cmd_q[`IPC_CMD_CLRNUM]) begin
      // R09 clear number and backup
      cardNum_q <= `IPC_ZERO;
      cardNumberBackup <= `IPC_ZERO;
    end else if (wrCardNum) begin
      // R13 number and backup copy
      cardNum_q <= wdata;
      cardNumberBackup <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // Logical device registers
  // ---------------------------------------------------------------
  logic [7:0] act_q;
  logic [7:0] rchk_q;
  logic [7:0] romHigh_q;
  logic [7:0] romLow_q;

  // R07 reset command restores power-up values
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      act_q <= `IPC_RST_ACT;
      rchk_q <= `IPC_RST_RCHK;
      romHigh_q <= `IPC_RST_ROMH;
      romLow_q <= `IPC_RST_ROML;
    end else if (cmd_q[`IPC_CMD_RESET]) begin
      act_q <= `IPC_RST_ACT;
      rchk_q <= `IPC_RST_RCHK;
      romHigh_q <= `IPC_RST_ROMH;
      romLow_q <= `IPC_RST_ROML;
    end else if (wrCfg) begin
      // R15 activate bit
      if (index_q == `IPC_IDX_ACT) begin
        act_q <= {7'h00, wdata[`IPC_ACT_BIT]};
      end
      if (index_q == `IPC_IDX_RCHK) begin
        rchk_q <= {6'h00, wdata[1:0]};
      end
      // R19 fixed-zero high bits
      if (index_q == `IPC_IDX_ROMH) begin
        romHigh_q <= wdata & `IPC_ROMH_MASK;
      end
      // R20 fixed-zero low bits
      if (index_q == `IPC_IDX_ROML) begin
        romLow_q <= wdata & `IPC_ROML_MASK;
      end
    end
  end

  assign unitActive = act_q[`IPC_ACT_BIT];
  // R17 check only while inactive
  assign rangeCheckActive = rchk_q[`IPC_RCHK_EN] && !act_q[`IPC_ACT_BIT];
  assign bootRomBase = {romHigh_q, romLow_q};
  // R22 size straight from serial memory
  assign bootRomSize = romSizeCfg;

  // ---------------------------------------------------------------
  // Read side effects
  // ---------------------------------------------------------------
  // R06 isolation compare pulse
  assign isolationCompare = dataRead && inIsolate && (index_q == `IPC_IDX_ISOL);
  // R12 advance resource stream
  assign resourceNext = dataRead && inConfig && (index_q == `IPC_IDX_RDATA);

  // ---------------------------------------------------------------
  // Read data multiplexer
  // ---------------------------------------------------------------
  logic [7:0] regRead;
  logic rangeRead;

  // R23 indexed register readback
  always_comb begin
    // R04 unlisted reads return zero
    regRead = `IPC_ZERO;
    if (index_q == `IPC_IDX_ISOL) begin
      regRead = isolationData;
    end else if (index_q == `IPC_IDX_RDATA) begin
      regRead = resourceByte;
    end else if (index_q == `IPC_IDX_STAT) begin
      // R12 ready flag
      regRead = {7'h00, resourceReady};
    end else if (index_q == `IPC_IDX_CARDNUM) begin
      regRead = cardNum_q;
    end else if (index_q == `IPC_IDX_LUN) begin
      // R14 single unit
      regRead = `IPC_LUN_VALUE;
    end else if (index_q == `IPC_IDX_ACT) begin
      regRead = act_q;
    end else if (index_q == `IPC_IDX_RCHK) begin
      regRead = rchk_q;
    end else if (index_q == `IPC_IDX_ROMH) begin
      regRead = romHigh_q;
    end else if (index_q == `IPC_IDX_ROML) begin
      regRead = romLow_q;
    end else if (index_q == `IPC_IDX_MCTL) begin
      // R21 eight bit only
      regRead = `IPC_MCTL_VALUE;
    end else if (index_q == `IPC_IDX_BACKUP) begin
      regRead = cardNumberBackup;
    end
  end

  // R18 range check pattern
  assign rangeRead = rangeCheckActive && ioRangeHit && inConfig;

  // Data is registered; the enable follows the synchronised strobe.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      isaDataOut <= `IPC_ZERO;
    end else if (rangeRead) begin
      isaDataOut <= rchk_q[`IPC_RCHK_PAT] ? `IPC_PAT_SET : `IPC_PAT_CLR;
    end else begin
      isaDataOut <= regRead;
    end
  end

  assign isaDataOe = !iorN && !iorPrev_q && (rportHit_ok || rangeRead);
  assign cardState = state_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_cmd_selfclear: assert property (cmd_q != 3'h0 |=> cmd_q == 3'h0 || $past(wrCmd)) // R10
    else $error("command bits did not clear");
  chk_number_backup: assert property (wrCardNum && !cmd_q[2] |=> cardNum_q == $past(wdata) // R13
    && cardNumberBackup == $past(wdata)) else $error("backup not recorded");
  chk_number_clear: assert property (cmd_q[2] |=> cardNum_q == 8'h00 // R09
    && cardNumberBackup == 8'h00) else $error("card number not cleared");
  chk_waitkey_cmd: assert property (cmd_q[1] && !cmd_q[2] |=> state_q == IPC_WAITKEY // R08
    && $stable(cardNum_q)) else $error("wait for key failed");
  chk_wake_iso: assert property (state_q == IPC_SLEEP && wrWake && wdata == 8'h00 // R11
    && cardNum_q == 8'h00 && !cmd_q[1] |=> state_q == IPC_ISOLATE) else $error("wake to iso");
  chk_rom_high: assert property ((romHigh_q & 8'hF2) == 8'h00) // R19
    else $error("rom high fixed bits set");
  chk_rom_low: assert property (romLow_q[5:0] == 6'h00) // R20
    else $error("rom low fixed bits set");
  chk_range_gate: assert property (unitActive |-> !rangeCheckActive) // R17
    else $error("range check while active");
  chk_reset_cmd: assert property (cmd_q[0] && !cmd_q[2] |=> act_q == 8'h00 // R07
    && rchk_q == 8'h00 && $stable(cardNum_q)) else $error("device reset incomplete");
  chk_index_hold: assert property (!(idxWrite && state_q != IPC_WAITKEY) |=> $stable(index_q)) // R02
    else $error("index changed without write");
  chk_range_data: assert property (rangeRead && rchk_q[0] |=> isaDataOut == 8'h55) // R18
    else $error("range pattern wrong");
  chk_lun_zero: assert property (index_q == 8'h07 && !rangeRead |=> isaDataOut == 8'h00) // R14
    else $error("unit number not zero");
  chk_write_gate: assert property (state_q == IPC_SLEEP |-> !wrCfg) // R24
    else $error("config write outside config");

  cov_key_done: cover property (state_q == IPC_WAITKEY ##1 state_q == IPC_SLEEP);
  cov_wake_cfg: cover property (state_q == IPC_SLEEP ##1 state_q == IPC_CONFIG);
  cov_iso_read: cover property (isolationCompare);
  cov_range_read: cover property (rangeRead && isaDataOe);

endmodule // ipc_config_regs

/* rtl/ipc_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes each bit is independent or stable while it is sampled.
`timescale 1ns/1ps

module ipc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second, so metastability is contained.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= INIT;
      syncOut <= INIT;
    end else begin
      meta_q <= pinIn;
      syncOut <= meta_q;
    end
  end

endmodule // ipc_sync

/* verification/ipc_isa_host.sv */
// ISA host model that runs plug and play configuration cycles.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps

`include "ipc_defines.svh"

module ipc_isa_host (
  input wire logic sys_clk,
  output logic [11:0] isaAddr,
  output logic [7:0] isaDataIn,
  output logic isaIorN,
  output logic isaIowN,
  input wire logic [7:0] isaDataOut,
  input wire logic isaDataOe
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // The bus starts idle with both strobes high.
  initial begin
    isaAddr = 12'h000;
    isaDataIn = 8'h00;
    isaIorN = 1'b1;
    isaIowN = 1'b1;
  end

  // Waits some clocks, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Address and data settle four clocks early, since the device samples them
  // through a synchroniser separate from the strobe's. Released data is inverted.
  task automatic io_write(input logic [11:0] addr, input logic [7:0] data);
    tick(1);
    isaAddr = addr;
    isaDataIn = data;
    tick(4);
    isaIowN = 1'b0;
    tick(4);
    isaIowN = 1'b1;
    tick(4);
    isaDataIn = ~data;
  endtask

  // The read strobe is held six clocks so the late output enable is seen.
  task automatic io_read(input logic [11:0] addr, output logic [7:0] data, output logic seen);
    seen = 1'b0;
    data = 8'h00;
    tick(1);
    isaAddr = addr;
    tick(4);
    isaIorN = 1'b0;
    // Sampled just after each edge, once the card's outputs have settled.
    repeat (6) begin
      tick(1);
      if (isaDataOe === 1'b1 && !seen) begin
        data = isaDataOut;
        seen = 1'b1;
      end
    end
    isaIorN = 1'b1;
    tick(4);
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
    io_write(`IPC_INDEX_PORT, idx);
    io_write(`IPC_WDATA_PORT, data);
  endtask

  task automatic send_key();
    logic [7:0] k;
    k = `IPC_KEY_SEED;
    repeat (32) begin
      io_write(`IPC_INDEX_PORT, k);
      k = {k[1] ^ k[0], k[7:1]};
    end
  endtask
endmodule // ipc_isa_host

/* verification/tb_top.sv */
// Self-checking bench for the plug and play configuration registers.
// Assumes the package, the defines header and the design are compiled first.
`timescale 1ns/1ps

`include "ipc_defines.svh"

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
    end \
  end

module tb_top
  import ipc_pkg::*;
;
  typedef struct packed {
    logic [7:0] idx;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } ipc_row_t;

  // Read port for locator byte 80H: bits 9..2 from it, bits 1..0 ones.
  localparam logic [11:0] RPORT = 12'h203;
  localparam int LIMIT = 20000;

  logic sys_clk, nrst, isaIorN, isaIowN, isaDataOe, ioRangeHit, resourceReady;
  logic resourceNext, isolationCompare, unitActive, rangeCheckActive, seen;
  logic [11:0] isaAddr;
  logic [7:0] isaDataIn, isaDataOut, resourceByte, isolationData, cardNumberBackup, rd;
  logic [1:0] romSizeCfg, bootRomSize, cardState;
  logic [15:0] bootRomBase;
  int error_cnt = 0;
  int n_compared = 0;
  int nextCnt = 0;
  int cmpCnt = 0;

  // Ordinary cases: index, write flag, write data, expected read.
  ipc_row_t rows [11] = '{
    '{8'h40, 1'b1, 8'hFF, 8'h0D},
    '{8'h41, 1'b1, 8'hFF, 8'hC0},
    '{8'h07, 1'b0, 8'h00, 8'h00},
    '{8'h42, 1'b0, 8'h00, 8'h00},
    '{8'hF5, 1'b0, 8'h00, 8'h05},
    '{8'h06, 1'b0, 8'h00, 8'h05},
    '{8'h02, 1'b0, 8'h00, 8'h00},
    '{8'h55, 1'b1, 8'hFF, 8'h00},
    '{8'h05, 1'b0, 8'h00, 8'h01},
    '{8'h30, 1'b1, 8'hFF, 8'h01},
    '{8'h30, 1'b1, 8'h00, 8'h00}
  };

  ipc_config_regs i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .isaAddr(isaAddr), .isaDataIn(isaDataIn),
    .isaIorN(isaIorN), .isaIowN(isaIowN), .isaDataOut(isaDataOut),
    .isaDataOe(isaDataOe), .ioRangeHit(ioRangeHit), .resourceByte(resourceByte),
    .resourceReady(resourceReady), .resourceNext(resourceNext),
    .isolationData(isolationData), .isolationCompare(isolationCompare),
    .romSizeCfg(romSizeCfg), .bootRomSize(bootRomSize), .bootRomBase(bootRomBase),
    .unitActive(unitActive), .rangeCheckActive(rangeCheckActive),
    .cardNumberBackup(cardNumberBackup), .cardState(cardState)
  );

  ipc_isa_host i_host (
    .sys_clk(sys_clk), .isaAddr(isaAddr), .isaDataIn(isaDataIn), .isaIorN(isaIorN),
    .isaIowN(isaIowN), .isaDataOut(isaDataOut), .isaDataOe(isaDataOe)
  );

  // ---------------------------------------------------------------
  // Clock, pulse counters and helpers
  // ---------------------------------------------------------------
  // A 100 ns clock period.
  always #50 sys_clk = ~sys_clk;

  // Side pulses last one cycle; counting at the falling edge avoids racing the launch edge.
  always @(negedge sys_clk) begin
    if (resourceNext === 1'b1) begin
      nextCnt++;
    end
    if (isolationCompare === 1'b1) begin
      cmpCnt++;
    end
  end

  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d, output logic s);
    i_host.io_write(`IPC_INDEX_PORT, idx);
    i_host.io_read(RPORT, d, s);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hang cannot outlast a generous multiple of the expected run.
  initial begin
    #(LIMIT * 100);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    ioRangeHit = 1'b0;
    resourceByte = 8'hA5;
    resourceReady = 1'b1;
    isolationData = 8'h3C;
    romSizeCfg = 2'h2;
    repeat (20) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    `CHK(cardState, IPC_WAITKEY)
    `CHK(bootRomBase, 16'h0000)
    end_test("reset");
    i_host.send_key();
    `CHK(cardState, IPC_SLEEP)
    i_host.reg_wr(`IPC_IDX_WAKE, 8'h00);
    `CHK(cardState, IPC_ISOLATE)
    i_host.reg_wr(`IPC_IDX_RPORT, 8'h80);
    rd_reg(`IPC_IDX_ISOL, rd, seen);
    `CHK(seen, 1'b1)
    `CHK(rd, 8'h3C)
    `CHK(cmpCnt, 1)
    i_host.reg_wr(`IPC_IDX_CARDNUM, 8'h05);
    `CHK(cardState, IPC_CONFIG)
    `CHK(cardNumberBackup, 8'h05)
    end_test("isolation");
    for (int i = 0; i < 11; i++) begin
      i_host.io_write(`IPC_INDEX_PORT, rows[i].idx);
      if (rows[i].wr) begin
        i_host.io_write(`IPC_WDATA_PORT, rows[i].wdata);
      end
      i_host.io_read(RPORT, rd, seen);
      `CHK(rd, rows[i].exp)
    end
    end_test("table");
    // One index serves several data accesses.
    i_host.reg_wr(`IPC_IDX_ROMH, 8'h05);
    i_host.io_read(RPORT, rd, seen);
    `CHK(rd, 8'h05)
    i_host.io_write(`IPC_WDATA_PORT, 8'h08);
    i_host.io_read(RPORT, rd, seen);
    `CHK(rd, 8'h08)
    `CHK(bootRomBase, 16'h08C0)
    end_test("index");
    i_host.reg_wr(`IPC_IDX_RCHK, 8'h03);
    `CHK(rangeCheckActive, 1'b1)
    ioRangeHit = 1'b1;
    i_host.io_read(12'h300, rd, seen);
    `CHK(rd, 8'h55)
    i_host.io_write(`IPC_WDATA_PORT, 8'h02);
    i_host.io_read(12'h300, rd, seen);
    `CHK(rd, 8'hAA)
    ioRangeHit = 1'b0;
    i_host.io_write(`IPC_WDATA_PORT, 8'h00);
    i_host.reg_wr(`IPC_IDX_ACT, 8'h01);
    i_host.reg_wr(`IPC_IDX_RCHK, 8'h02);
    `CHK(rangeCheckActive, 1'b0)
    `CHK(unitActive, 1'b1)
    end_test("range");
    rd_reg(`IPC_IDX_STAT, rd, seen);
    `CHK(rd, 8'h01)
    rd_reg(`IPC_IDX_RDATA, rd, seen);
    `CHK(rd, 8'hA5)
    `CHK(nextCnt, 1)
    end_test("resource");
    i_host.reg_wr(`IPC_IDX_CMD, 8'h01);
    `CHK(bootRomBase, 16'h0000)
    `CHK(unitActive, 1'b0)
    `CHK(cardNumberBackup, 8'h05)
    // A command bit left standing would wipe this write again.
    i_host.reg_wr(`IPC_IDX_ROMH, 8'h05);
    `CHK(bootRomBase, 16'h0500)
    i_host.reg_wr(`IPC_IDX_CMD, 8'h02);
    `CHK(cardState, IPC_WAITKEY)
    `CHK(cardNumberBackup, 8'h05)
    rd_reg(`IPC_IDX_CARDNUM, rd, seen);
    `CHK(seen, 1'b0)
    end_test("commands");
    i_host.send_key();
    i_host.reg_wr(`IPC_IDX_WAKE, 8'h05);
    `CHK(cardState, IPC_CONFIG)
    i_host.io_read(12'h207, rd, seen);
    `CHK(seen, 1'b0)
    i_host.reg_wr(`IPC_IDX_CMD, 8'h04);
    `CHK(cardNumberBackup, 8'h00)
    rd_reg(`IPC_IDX_CARDNUM, rd, seen);
    `CHK(rd, 8'h00)
    `CHK(bootRomSize, 2'h2)
    end_test("wake");
    // A bus reset in mid-run drops the card back to key wait with cleared registers.
    nrst = 1'b0;
    i_host.tick(2);
    nrst = 1'b1;
    `CHK(cardState, IPC_WAITKEY)
    `CHK(bootRomBase, 16'h0000)
    i_host.tick(2);
    `CHK(cardState, IPC_WAITKEY)
    end_test("midreset");
    wrap_up();
  end
endmodule // tb_top
